// File: core/smd_consts.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SMD_CONSTS_SVH
`define SMD_CONSTS_SVH

`define SMD_OFS_START     12'h010
`define SMD_OFS_STATUS    12'h300
`define SMD_OFS_INTMASK   12'h30C
`define SMD_OFS_RATE      12'h524
`define SMD_OFS_RX_PTR    12'h534
`define SMD_OFS_RX_MAX    12'h538
`define SMD_OFS_RX_DONE   12'h53C
`define SMD_OFS_RX_LIST   12'h540
`define SMD_OFS_TX_PTR    12'h544
`define SMD_OFS_TX_MAX    12'h548
`define SMD_OFS_TX_DONE   12'h54C
`define SMD_OFS_TX_LIST   12'h550
`define SMD_OFS_CFG       12'h554
`define SMD_OFS_FILLER    12'h5C0
`define SMD_OFS_LATENCY   12'h5D0

`define SMD_EV_RX_BUFFER_DONE_EVENT      0
`define SMD_EV_END        1
`define SMD_EV_TX_BUFFER_DONE_EVENT      2
`define SMD_CFG_ORDER     0
`define SMD_CFG_CPHA      1
`define SMD_CFG_CPOL      2
`define SMD_START_BIT     0
`define SMD_LAT_LOWPWR    0

`define SMD_RST_RATE      32'h0400_0000
`define SMD_RST_ZERO      32'h0000_0000

`define SMD_RATE_125K     32'h0200_0000
`define SMD_RATE_250K     32'h0400_0000
`define SMD_RATE_500K     32'h0800_0000
`define SMD_RATE_1M       32'h1000_0000
`define SMD_RATE_2M       32'h2000_0000
`define SMD_RATE_4M       32'h4000_0000
`define SMD_RATE_8M       32'h8000_0000

`define SMD_PCLK_HZ       20000000
`define SMD_HALF_125K     (`SMD_PCLK_HZ / (2 * 125000))
`define SMD_HALF_250K     (`SMD_PCLK_HZ / (2 * 250000))
`define SMD_HALF_500K     (`SMD_PCLK_HZ / (2 * 500000))
`define SMD_HALF_1M       (`SMD_PCLK_HZ / (2 * 1000000))
`define SMD_HALF_2M       (`SMD_PCLK_HZ / (2 * 2000000))
`define SMD_HALF_4M       (`SMD_PCLK_HZ / (2 * 4000000))
`define SMD_HALF_8M       (`SMD_PCLK_HZ / (2 * 8000000))

`define SMD_START_CL_NS   1000
`define SMD_START_CL_CYC  ((`SMD_START_CL_NS * (`SMD_PCLK_HZ / 1000000)) / 1000)

`endif

// File: core/smd_pkg.sv
// Types shared by the serial master unit.
package smd_pkg;

  typedef enum logic [2:0] {
    SMD_IDLE  = 3'b000,
    SMD_DELAY = 3'b001,
    SMD_NEXT  = 3'b010,
    SMD_FETCH = 3'b011,
    SMD_SHIFT = 3'b100,
    SMD_STORE = 3'b101,
    SMD_DONE  = 3'b110
  } smd_state_t;

endpackage : smd_pkg

// File: core/smd_spi_master.sv
// Serial master unit with buffer access, APB registers and interrupt.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "smd_consts.svh"

// Functional notes
// - Receive max count register limits bytes stored to the receive buffer.
// - Transmit max count register limits bytes fetched from transmit buffer.
// - Read-only done counts per direction updated after each transaction.
// - List kind 0 keeps one buffer, 1 steps to the next buffer.
// - Config bit 0 order, bit 1 phase, bit 2 polarity; 1 means low bit first.
// - Phase 0 samples leading, shifts trailing; phase 1 the reverse.
// - Polarity 0 idles clock low, polarity 1 idles clock high.
// - Past the transmit buffer end the filler byte is shifted out.
// - Constant latency mode starts shifting about 1 us after start.
// - Low power mode adds high frequency clock start-up to that delay.
// - Combined end event when both buffers are fully processed.
// - Receive end event when the receive buffer end is reached.
// - Transmit end event when the transmit buffer end is reached.
module smd_spi_master #(
  parameter int unsigned HFCLK_START_CYC = 800
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             sck,
  output logic             mosi,
  input  wire logic        miso,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  output logic             irq
);
  import smd_pkg::*;

  localparam int unsigned LP_CYC = `SMD_START_CL_CYC + HFCLK_START_CYC;

  smd_state_t  state_q;
  logic [31:0] rate_q;
  logic [31:0] rx_ptr_q;
  logic [7:0]  rx_max_q;
  logic [7:0]  rx_done_q;
  logic [2:0]  rx_list_q;
  logic [31:0] tx_ptr_q;
  logic [7:0]  tx_max_q;
  logic [7:0]  tx_done_q;
  logic [2:0]  tx_list_q;
  logic [2:0]  cfg_q;
  logic [7:0]  filler_q;
  logic        lowpwr_q;
  logic [2:0]  status_q;
  logic [2:0]  mask_q;
  logic [7:0]  rx_cnt_q;
  logic [7:0]  tx_cnt_q;
  logic [7:0]  pos_q;
  logic [15:0] dly_q;
  logic [6:0]  div_q;
  logic [3:0]  edge_q;
  logic [7:0]  txsh_q;
  logic [7:0]  rxsh_q;
  logic [7:0]  rx_full;
  logic        sck_q;
  logic        miso_s1_q;
  logic        miso_s2_q;
  logic        wr_en;
  logic        start_w;
  logic        tick;
  logic        sample_edge;
  logic        shift_edge;
  logic [6:0]  half_cyc;
  logic [7:0]  total;
  logic [2:0]  ev_set;

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic addr_ok(input logic [11:0] a);
    case (a)
      `SMD_OFS_START, `SMD_OFS_STATUS, `SMD_OFS_INTMASK, `SMD_OFS_RATE,
      `SMD_OFS_RX_PTR, `SMD_OFS_RX_MAX, `SMD_OFS_RX_DONE, `SMD_OFS_RX_LIST,
      `SMD_OFS_TX_PTR, `SMD_OFS_TX_MAX, `SMD_OFS_TX_DONE, `SMD_OFS_TX_LIST,
      `SMD_OFS_CFG, `SMD_OFS_FILLER, `SMD_OFS_LATENCY: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7-i];
    end
  endfunction : rev8

  // Unsupported rate codes fall back to the slowest rate.
  function automatic logic [6:0] half_of(input logic [31:0] r);
    case (r)
      `SMD_RATE_250K: half_of = 7'(`SMD_HALF_250K);
      `SMD_RATE_500K: half_of = 7'(`SMD_HALF_500K);
      `SMD_RATE_1M:   half_of = 7'(`SMD_HALF_1M);
      `SMD_RATE_2M:   half_of = 7'(`SMD_HALF_2M);
      `SMD_RATE_4M:   half_of = 7'(`SMD_HALF_4M);
      `SMD_RATE_8M:   half_of = 7'(`SMD_HALF_8M);
      default:        half_of = 7'(`SMD_HALF_125K);
    endcase
  endfunction : half_of

  //////////////////////////////////////////////////////////////////////////////
  // APB slave.

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign wr_en   = psel & penable & pwrite & addr_ok(paddr);
  assign start_w = wr_en & (paddr == `SMD_OFS_START) & pwdata[`SMD_START_BIT];

  // Read data is captured in the setup cycle and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `SMD_RST_ZERO;
    end else if (psel && !penable) begin
      case (paddr)
        `SMD_OFS_STATUS:  prdata <= {29'h0, status_q};
        `SMD_OFS_INTMASK: prdata <= {29'h0, mask_q};
        `SMD_OFS_RATE:    prdata <= rate_q;
        `SMD_OFS_RX_PTR:  prdata <= rx_ptr_q;
        `SMD_OFS_RX_MAX:  prdata <= {24'h0, rx_max_q};
        `SMD_OFS_RX_DONE: prdata <= {24'h0, rx_done_q};
        `SMD_OFS_RX_LIST: prdata <= {29'h0, rx_list_q};
        `SMD_OFS_TX_PTR:  prdata <= tx_ptr_q;
        `SMD_OFS_TX_MAX:  prdata <= {24'h0, tx_max_q};
        `SMD_OFS_TX_DONE: prdata <= {24'h0, tx_done_q};
        `SMD_OFS_TX_LIST: prdata <= {29'h0, tx_list_q};
        `SMD_OFS_CFG:     prdata <= {29'h0, cfg_q};
        `SMD_OFS_FILLER:  prdata <= {24'h0, filler_q};
        `SMD_OFS_LATENCY: prdata <= {31'h0, lowpwr_q};
        default:          prdata <= `SMD_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q    <= `SMD_RST_RATE;
      rx_max_q  <= 8'h00;
      rx_list_q <= 3'h0;
      tx_max_q  <= 8'h00;
      tx_list_q <= 3'h0;
      cfg_q     <= 3'h0;
      filler_q  <= 8'h00;
      lowpwr_q  <= 1'b0;
      mask_q    <= 3'h0;
    end else if (wr_en) begin
      case (paddr)
        `SMD_OFS_RATE:    rate_q    <= pwdata;
        `SMD_OFS_RX_MAX:  rx_max_q  <= pwdata[7:0];
        `SMD_OFS_RX_LIST: rx_list_q <= pwdata[2:0];
        `SMD_OFS_TX_MAX:  tx_max_q  <= pwdata[7:0];
        `SMD_OFS_TX_LIST: tx_list_q <= pwdata[2:0];
        `SMD_OFS_CFG:     cfg_q     <= pwdata[2:0];
        `SMD_OFS_FILLER:  filler_q  <= pwdata[7:0];
        `SMD_OFS_LATENCY: lowpwr_q  <= pwdata[`SMD_LAT_LOWPWR];
        `SMD_OFS_INTMASK: mask_q    <= pwdata[2:0];
        default:          mask_q    <= mask_q;
      endcase
    end
  end

  // In list mode each pointer steps past its buffer when a transaction ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ptr_q <= `SMD_RST_ZERO;
      tx_ptr_q <= `SMD_RST_ZERO;
    end else begin
      if (wr_en && paddr == `SMD_OFS_RX_PTR) begin
        rx_ptr_q <= pwdata;
      end else if (state_q == SMD_DONE && rx_list_q == 3'h1) begin
        rx_ptr_q <= rx_ptr_q + {24'h0, rx_max_q};
      end
      if (wr_en && paddr == `SMD_OFS_TX_PTR) begin
        tx_ptr_q <= pwdata;
      end else if (state_q == SMD_DONE && tx_list_q == 3'h1) begin
        tx_ptr_q <= tx_ptr_q + {24'h0, tx_max_q};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events and interrupt; a new event wins over a clear in the same cycle.

  always_comb begin
    ev_set = 3'h0;
    if (state_q == SMD_FETCH && mem_ack && tx_cnt_q + 8'h01 == tx_max_q) begin
      ev_set[`SMD_EV_TX_BUFFER_DONE_EVENT] = 1'b1;
    end
    if (state_q == SMD_STORE && mem_ack && rx_cnt_q + 8'h01 == rx_max_q) begin
      ev_set[`SMD_EV_RX_BUFFER_DONE_EVENT] = 1'b1;
    end
    if (state_q == SMD_DONE) begin
      ev_set[`SMD_EV_END] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 3'h0;
    end else if (wr_en && paddr == `SMD_OFS_STATUS) begin
      status_q <= (status_q & ~pwdata[2:0]) | ev_set;
    end else begin
      status_q <= status_q | ev_set;
    end
  end

  assign irq = |(status_q & mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer.

  assign total = (rx_max_q > tx_max_q) ? rx_max_q : tx_max_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SMD_IDLE;
    end else begin
      case (state_q)
        SMD_IDLE: begin
          if (start_w) begin
            state_q <= SMD_DELAY;
          end
        end
        SMD_DELAY: begin
          if (dly_q == (lowpwr_q ? 16'(LP_CYC - 1)
                                 : 16'(`SMD_START_CL_CYC - 1))) begin
            state_q <= SMD_NEXT;
          end
        end
        SMD_NEXT: begin
          if (pos_q == total) begin
            state_q <= SMD_DONE;
          end else if (tx_cnt_q < tx_max_q) begin
            state_q <= SMD_FETCH;
          end else begin
            state_q <= SMD_SHIFT;
          end
        end
        SMD_FETCH: begin
          if (mem_ack) begin
            state_q <= SMD_SHIFT;
          end
        end
        SMD_SHIFT: begin
          if (tick && edge_q == 4'hF) begin
            state_q <= (rx_cnt_q < rx_max_q) ? SMD_STORE : SMD_NEXT;
          end
        end
        SMD_STORE: begin
          if (mem_ack) begin
            state_q <= SMD_NEXT;
          end
        end
        SMD_DONE: state_q <= SMD_IDLE;
        default:  state_q <= SMD_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q <= 16'h0000;
    end else begin
      dly_q <= (state_q == SMD_DELAY) ? dly_q + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_q  <= 8'h00;
      tx_cnt_q  <= 8'h00;
      pos_q     <= 8'h00;
      rx_done_q <= 8'h00;
      tx_done_q <= 8'h00;
    end else begin
      if (state_q == SMD_IDLE && start_w) begin
        rx_cnt_q <= 8'h00;
        tx_cnt_q <= 8'h00;
        pos_q    <= 8'h00;
      end
      if (state_q == SMD_FETCH && mem_ack) begin
        tx_cnt_q <= tx_cnt_q + 8'h01;
      end
      if (state_q == SMD_STORE && mem_ack) begin
        rx_cnt_q <= rx_cnt_q + 8'h01;
      end
      if (state_q == SMD_SHIFT && tick && edge_q == 4'hF) begin
        pos_q <= pos_q + 8'h01;
      end
      if (state_q == SMD_DONE) begin
        rx_done_q <= rx_cnt_q;
        tx_done_q <= tx_cnt_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Buffer memory port; the request holds until acknowledged.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= `SMD_RST_ZERO;
      mem_wdata <= 8'h00;
    end else if (mem_req) begin
      if (mem_ack) begin
        mem_req <= 1'b0;
      end
    end else if (state_q == SMD_NEXT && pos_q != total &&
                 tx_cnt_q < tx_max_q) begin
      mem_req  <= 1'b1;
      mem_we   <= 1'b0;
      mem_addr <= tx_ptr_q + {24'h0, tx_cnt_q};
    end else if (state_q == SMD_SHIFT && tick && edge_q == 4'hF &&
                 rx_cnt_q < rx_max_q) begin
      mem_req   <= 1'b1;
      mem_we    <= 1'b1;
      mem_addr  <= rx_ptr_q + {24'h0, rx_cnt_q};
      mem_wdata <= cfg_q[`SMD_CFG_ORDER] ? rev8(rx_full) : rx_full;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial clock divider and shifter.

  assign half_cyc = half_of(rate_q);
  assign tick     = (state_q == SMD_SHIFT) && (div_q == half_cyc - 7'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 7'h00;
    end else begin
      div_q <= (state_q != SMD_SHIFT || tick) ? 7'h00 : div_q + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= miso;
      miso_s2_q <= miso_s1_q;
    end
  end

  // Even edges are leading, odd edges trailing.
  assign sample_edge = (edge_q[0] == cfg_q[`SMD_CFG_CPHA]);
  assign shift_edge  = !sample_edge && (edge_q != 4'h0);
  assign rx_full     = sample_edge ? {rxsh_q[6:0], miso_s2_q} : rxsh_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_q <= 4'h0;
      sck_q  <= 1'b0;
      txsh_q <= 8'h00;
      rxsh_q <= 8'h00;
    end else begin
      if (state_q != SMD_SHIFT) begin
        sck_q  <= cfg_q[`SMD_CFG_CPOL];
        edge_q <= 4'h0;
      end else if (tick) begin
        sck_q  <= ~sck_q;
        edge_q <= edge_q + 4'h1;
        if (sample_edge) begin
          rxsh_q <= {rxsh_q[6:0], miso_s2_q};
        end
        if (shift_edge) begin
          txsh_q <= {txsh_q[6:0], 1'b0};
        end
      end
      if (state_q == SMD_FETCH && mem_ack) begin
        txsh_q <= cfg_q[`SMD_CFG_ORDER] ? rev8(mem_rdata) : mem_rdata;
      end else if (state_q == SMD_NEXT && tx_cnt_q >= tx_max_q) begin
        txsh_q <= cfg_q[`SMD_CFG_ORDER] ? rev8(filler_q) : filler_q;
      end
    end
  end

  assign sck  = sck_q;
  assign mosi = txsh_q[7];

endmodule : smd_spi_master

// File: bench/smd_slave_model.sv
// Behavioural serial slave facing the master link pins.
`timescale 1ns/10ps
module smd_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic       clr,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte,
  output int              n_bytes
);
  int         e = 0;
  int         k = 0;
  logic [7:0] sh = 8'h00;
  function automatic logic pick(input int i);
    return lsb ? tx_byte[i] : tx_byte[7 - i];
  endfunction : pick
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    n_bytes = 0;
  end
  // A polarity change moves the idle level, so framing restarts here.
  always @(posedge clr) begin
    e = 0;
    k = 0;
    miso = cpha ? ~miso : pick(0);
  end
  // Even edges lead and odd edges trail.
  always @(sck) begin
    if (e % 2 == int'(cpha)) begin
      sh[lsb ? k : 7 - k] = mosi;
      k = k + 1;
    end else if (e < 15) begin
      miso = pick((e + 1) / 2);
    end
    e = e + 1;
    if (e == 16) begin
      e = 0;
      k = 0;
      rx_byte = sh;
      n_bytes = n_bytes + 1;
      miso = cpha ? ~miso : pick(0);
    end
  end
endmodule : smd_slave_model

// File: bench/smd_spi_asserts.sv
// Port checks for the serial master unit, bound into the design.
`timescale 1ns/10ps
module smd_spi_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sck,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_at(logic [11:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  mem_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after ack");
  sck_still_a: assert property (mem_req |=> $stable(sck))
    else $error("serial clock moved during memory access");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  done_ok_a: assert property (psel && penable && pwrite
    && paddr inside {12'h053C, 12'h054C} |-> !pslverr)
    else $error("done count write flagged");
  cfg_narrow_a: assert property (rd_at(12'h0554) |-> prdata[31:3] == 0)
    else $error("config upper bits set");
  fill_narrow_a: assert property (rd_at(12'h05C0) |-> prdata[31:8] == 0)
    else $error("filler upper bits set");
  list_narrow_a: assert property (rd_at(12'h0540) |-> prdata[31:3] == 0)
    else $error("list kind upper bits set");
  cover property (mem_req && mem_ack && mem_we);
  cover property (mem_req && mem_ack && !mem_we);
  cover property (pslverr);
endmodule : smd_spi_chk

bind smd_spi_master smd_spi_chk i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pslverr, .sck, .mem_req, .mem_we, .mem_addr,
  .mem_wdata, .mem_ack);

// File: bench/spi_master_dma_buffer_config_tb.sv
// Self-checking bench for the serial master unit.
`timescale 1ns/10ps
`include "smd_consts.svh"
module spi_master_dma_buffer_config_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, mem_ack = 1'b0, cpol = 1'b0, cpha = 1'b0;
  logic lsb = 1'b0, clr = 1'b0, pready, pslverr, sck, mosi, miso, err;
  logic mem_req, mem_we, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, mem_addr, rd;
  logic [7:0]  mem_wdata, rx_byte, mem_rdata = 8'h00, tx_byte = 8'h00;
  logic [7:0]  wmem [256];
  int          n_fail = 0, cmp_count = 0, seed = 40384, n_wr = 0, n_bytes;
  logic [31:0] rate_t [7] = '{`SMD_RATE_125K, `SMD_RATE_250K,
    `SMD_RATE_500K, `SMD_RATE_1M, `SMD_RATE_2M, `SMD_RATE_4M, `SMD_RATE_8M};
  int          half_t [7] = '{80, 40, 20, 10, 5, 2, 1};
  logic [11:0] ofs [11] = '{12'h534, 12'h538, 12'h53C, 12'h540, 12'h544,
    12'h548, 12'h54C, 12'h550, 12'h554, 12'h5C0, 12'h524};

  always #25 pclk = ~pclk;

  smd_spi_master #(.HFCLK_START_CYC(4)) i_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sck,
    .mosi, .miso, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack, .irq);
  smd_slave_model i_slv (.sck, .mosi, .cpha, .lsb, .clr, .tx_byte, .miso,
    .rx_byte, .n_bytes);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] fb(input logic [31:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : fb
  // Buffer memory answers after a random stall.
  always @(posedge pclk) begin
    mem_ack <= 1'b0;
    if (mem_req && !mem_ack && $random(seed) % 2 == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= fb(mem_addr);
      if (mem_we) begin
        wmem[mem_addr[7:0]] = mem_wdata;
        n_wr++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  task automatic run(input int i);
    logic [31:0] rp, tp, cfg, over_read_filler;
    int          rx, tx, n, c, h, k, lo, hf;
    logic        s;
    rp = $random(seed);
    tp = $random(seed);
    over_read_filler = $random(seed) & 32'h0000_00FF;
    cfg = $random(seed) & 32'h0000_0007;
    rx = i == 0 ? 0 : (i == 1 ? 4 : ($random(seed) & 3) + 1);
    tx = i == 0 ? 0 : (i == 1 ? 1 : $random(seed) & 3);
    hf = (i == 9) ? 80 : half_t[i % 7];
    lo = (i == 3) ? 24 : 20;
    {cpol, cpha, lsb} <= cfg[2:0];
    tx_byte <= 8'($random(seed));
    apb(1, 12'h534, rp);
    apb(1, 12'h538, rx);
    apb(1, 12'h540, i % 2);
    apb(1, 12'h544, tp);
    apb(1, 12'h548, tx);
    apb(1, 12'h550, i % 2);
    apb(1, 12'h554, cfg);
    apb(1, 12'h5C0, over_read_filler);
    apb(1, 12'h524, (i == 9) ? 32'h0000_0001 : rate_t[i % 7]);
    apb(1, 12'h5D0, i == 3);
    apb(1, 12'h30C, i == 2 ? 0 : 7);
    repeat (3) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    n = rx > tx ? rx : tx;
    c = n_wr;
    h = n_bytes;
    apb(1, 12'h010, 1);
    if (n > 0) begin
      for (k = 0; k < 3000 && sck === cpol; k++) @(negedge pclk);
      chk(32'(k >= lo + hf - 1 && k <= lo + hf + 12), 1, "delay");
      s = sck;
      k = 0;
      do begin
        @(negedge pclk);
        k++;
      end while (sck === s && k < 200);
      chk(k, hf, "half period");
    end
    k = 0;
    do begin
      apb(0, 12'h300, 0);
      k++;
    end while (rd[1] !== 1'b1 && k < 3000);
    chk(rd, {29'h0, tx != 0, 1'b1, rx != 0}, "status");
    chk(32'(irq), i != 2, "irq");
    apb(1, 12'h300, 7);
    @(posedge pclk);
    chk(32'(irq), 0, "irq cleared");
    apb(1, 12'h54C, 32'h0000_00FF);
    apb(0, 12'h54C, 0);
    chk(rd, tx, "tx done");
    apb(0, 12'h53C, 0);
    chk(rd, rx, "rx done");
    chk(n_bytes - h, n, "bytes");
    chk(n_wr - c, rx, "stores");
    if (n > 0)
      chk(rx_byte, n <= tx ? fb(tp + n - 1) : over_read_filler[7:0], "mosi");
    if (rx > 0 && hf >= 5)
      chk(wmem[8'(rp + rx - 1)], tx_byte, "miso");
    apb(0, 12'h534, 0);
    chk(rd, i % 2 ? rp + rx : rp, "rx pointer");
    apb(0, 12'h544, 0);
    chk(rd, i % 2 ? tp + tx : tp, "tx pointer");
  endtask : run

  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[j]) begin
      apb(0, ofs[j], 0);
      chk(rd, ofs[j] == 12'h524 ? `SMD_RST_RATE : 0, "reset");
    end
    apb(0, 12'h004, 0);
    chk(32'(err), 32'h0000_0001, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped read");
    for (int i = 0; i < 10; i++) run(i);
    finish_test();
  end
endmodule : spi_master_dma_buffer_config_tb
